// ===== verilog/smc_regs.vh
/*
  Register offsets, field positions, reset values and codes of the
  supply monitor control block.
  Assumes a CPU I/O address of nine bits, the bank select coming on a separate flag.
*/
`ifndef SMC_REGS_VH
`define SMC_REGS_VH

`define SMC_ADDR_W          9
`define SMC_CONFIG_ADDR     9'h1e3
`define SMC_STATUS_ADDR     9'h1e4
`define SMC_DUTY_ADDR       9'h1eb

`define SMC_CONFIG_RESET    8'h00
`define SMC_DUTY_RESET      8'h00
`define SMC_RDATA_IDLE      8'h00
`define SMC_STS_PAD         6'h00
`define SMC_LVT_RESET       3'h0
`define SMC_CNT_STEP        10'h001
`define SMC_CONFIG_WMASK    8'h37
`define SMC_DUTY_WMASK      8'hc0

`define SMC_PRL_HI          5
`define SMC_PRL_LO          4
`define SMC_LVT_HI          2
`define SMC_LVT_LO          0
`define SMC_DUTY_HI         7
`define SMC_DUTY_LO         6

`define SMC_PRL_2V7         2'h0
`define SMC_PRL_3V0         2'h1
`define SMC_PRL_RSVD        2'h2
`define SMC_PRL_NORESET     2'h3

`define SMC_DUTY_128        2'h0
`define SMC_DUTY_512        2'h1
`define SMC_DUTY_32         2'h2
`define SMC_DUTY_8          2'h3

`define SMC_ON_PERIODS      10'h001
`define SMC_OFF_128         10'h07f
`define SMC_OFF_512         10'h1ff
`define SMC_OFF_32          10'h01f
`define SMC_OFF_8           10'h007
`define SMC_CNT_W           10

`endif

// ===== verilog/smc_supply_monitor_control.v
/*
  Supply monitor control: configuration, comparator status and duty
  cycle registers, reset request and low-voltage interrupt request.
  Assumes analog comparators outside, a 32 kHz clock input sampled in
  the CPU domain, and a CPU bus giving address, strobes and the bank flag.
*/
`timescale 1ns/1ns
`include "smc_regs.vh"

module smc_supply_monitor_control (
  input  wire                    clk,
  input  wire                    resetn,
  input  wire [`SMC_ADDR_W-1:0]  cpu_addr,
  input  wire                    extended_io_bank_flag,
  input  wire                    cpu_wr,
  input  wire                    cpu_rd,
  input  wire [7:0]              cpu_wdata,
  input  wire                    sleep_active,
  input  wire                    lsosc_32k,
  input  wire                    precision_reset_comparator,
  input  wire                    low_voltage_comparator,
  output reg  [7:0]              cpu_rdata,
  output reg                     cpu_rd_hit,
  output reg  [1:0]              precision_reset_level,
  output reg  [2:0]              low_voltage_trip_select,
  output reg                     system_reset_req,
  output reg                     low_voltage_irq,
  output reg                     flash_enable,
  output reg                     monitor_power_on
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg  [7:0]            supply_monitor_config;
  reg  [7:0]            monitor_duty_cycle;
  reg  [7:0]            next_cpu_rdata;
  reg                   next_cpu_rd_hit;

  // ----------------------------------------
  // Synchroniser storage
  // ----------------------------------------
  reg                   prc_meta;
  reg                   prc_sync;
  reg                   lvc_meta;
  reg                   lvc_sync;
  reg                   clk32_meta;
  reg                   clk32_sync;
  reg                   lvc_prev;
  reg                   clk32_prev;

  // ----------------------------------------
  // Duty cycle storage
  // ----------------------------------------
  reg  [`SMC_CNT_W-1:0] period_cnt;
  reg  [`SMC_CNT_W-1:0] next_period_cnt;
  reg                   next_power_on;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function reg_hit;
    input                   bank;
    input [`SMC_ADDR_W-1:0] addr;
    input [`SMC_ADDR_W-1:0] target;
    begin
      reg_hit = bank && (addr == target);
    end
  endfunction

  wire                  sel_cfg;
  wire                  sel_sts;
  wire                  sel_duty;
  wire                  wr_cfg;
  wire                  wr_duty;
  wire                  rd_any;

  // Bank flag gates every access
  assign sel_cfg  = reg_hit(extended_io_bank_flag, cpu_addr, `SMC_CONFIG_ADDR);
  assign sel_sts  = reg_hit(extended_io_bank_flag, cpu_addr, `SMC_STATUS_ADDR);
  assign sel_duty = reg_hit(extended_io_bank_flag, cpu_addr, `SMC_DUTY_ADDR);
  assign wr_cfg   = cpu_wr && sel_cfg;
  assign wr_duty  = cpu_wr && sel_duty;
  assign rd_any   = cpu_rd && (sel_cfg || sel_sts || sel_duty);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prc_meta   <= 1'b0;
      prc_sync   <= 1'b0;
      lvc_meta   <= 1'b0;
      lvc_sync   <= 1'b0;
      clk32_meta <= 1'b0;
      clk32_sync <= 1'b0;
    end else begin
      prc_meta   <= precision_reset_comparator;
      prc_sync   <= prc_meta;
      lvc_meta   <= low_voltage_comparator;
      lvc_sync   <= lvc_meta;
      clk32_meta <= lsosc_32k;
      clk32_sync <= clk32_meta;
    end
  end

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  // Reserved bits masked so they read zero
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      supply_monitor_config <= `SMC_CONFIG_RESET;
    end else if (wr_cfg) begin
      supply_monitor_config <= cpu_wdata & `SMC_CONFIG_WMASK;
    end
  end

  // ----------------------------------------
  // Duty cycle register
  // ----------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      monitor_duty_cycle <= `SMC_DUTY_RESET;
    end else if (wr_duty) begin
      monitor_duty_cycle <= cpu_wdata & `SMC_DUTY_WMASK;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Refused or unmapped reads return zero
  always @* begin
    next_cpu_rd_hit = rd_any;
    next_cpu_rdata  = `SMC_RDATA_IDLE;
    if (cpu_rd && sel_cfg) begin
      next_cpu_rdata = supply_monitor_config;
    end else if (cpu_rd && sel_duty) begin
      next_cpu_rdata = monitor_duty_cycle;
    end else if (cpu_rd && sel_sts) begin
      next_cpu_rdata = {`SMC_STS_PAD, lvc_sync, prc_sync};
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_rdata  <= `SMC_RDATA_IDLE;
      cpu_rd_hit <= 1'b0;
    end else begin
      cpu_rdata  <= next_cpu_rdata;
      cpu_rd_hit <= next_cpu_rd_hit;
    end
  end

  // ----------------------------------------
  // Analog trip point controls
  // ----------------------------------------
  wire [1:0]            prl_field;
  wire [2:0]            lvt_field;
  assign prl_field = supply_monitor_config[`SMC_PRL_HI:`SMC_PRL_LO];
  assign lvt_field = supply_monitor_config[`SMC_LVT_HI:`SMC_LVT_LO];

  // Level 11 goes to precision_reset_level unchanged, not as the 3 V code
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      precision_reset_level   <= `SMC_PRL_2V7;
      low_voltage_trip_select <= `SMC_LVT_RESET;
    end else begin
      precision_reset_level   <= prl_field;
      low_voltage_trip_select <= lvt_field;
    end
  end

  // ----------------------------------------
  // System reset request
  // ----------------------------------------
  // Code 10 still resets; only 11 suppresses
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      system_reset_req <= 1'b0;
    end else begin
      system_reset_req <= prc_sync && (prl_field != `SMC_PRL_NORESET);
    end
  end

  // ----------------------------------------
  // Low-voltage interrupt and flash enable
  // ----------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lvc_prev        <= 1'b0;
      low_voltage_irq <= 1'b0;
      flash_enable    <= 1'b0;
    end else begin
      lvc_prev        <= lvc_sync;
      low_voltage_irq <= lvc_sync && !lvc_prev;
      flash_enable    <= !lvc_sync;
    end
  end

  // ----------------------------------------
  // Duty cycle timing
  // ----------------------------------------
  function [`SMC_CNT_W-1:0] off_periods;
    input [1:0] code;
    begin
      case (code)
        `SMC_DUTY_128: off_periods = `SMC_OFF_128;
        `SMC_DUTY_512: off_periods = `SMC_OFF_512;
        `SMC_DUTY_32:  off_periods = `SMC_OFF_32;
        default:       off_periods = `SMC_OFF_8;
      endcase
    end
  endfunction

  wire [1:0]            duty_code;
  wire                  tick32;
  assign duty_code = monitor_duty_cycle[`SMC_DUTY_HI:`SMC_DUTY_LO];
  assign tick32    = clk32_sync && !clk32_prev;

  // One on period, then the off periods; awake stays on
  always @* begin
    next_period_cnt = period_cnt;
    next_power_on   = monitor_power_on;
    if (!sleep_active) begin
      next_period_cnt = {`SMC_CNT_W{1'b0}};
      next_power_on   = 1'b1;
    end else if (tick32) begin
      if (period_cnt >= off_periods(duty_code)) begin
        next_period_cnt = {`SMC_CNT_W{1'b0}};
      end else begin
        next_period_cnt = period_cnt + `SMC_CNT_STEP;
      end
      next_power_on = (next_period_cnt < `SMC_ON_PERIODS);
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk32_prev       <= 1'b0;
      period_cnt       <= {`SMC_CNT_W{1'b0}};
      monitor_power_on <= 1'b1;
    end else begin
      clk32_prev       <= clk32_sync;
      period_cnt       <= next_period_cnt;
      monitor_power_on <= next_power_on;
    end
  end

endmodule

// ===== sim/smc_supply_monitor_control_asserts.sv
/* Port checker of the supply monitor control block.
   Assumes it is bound into smc_supply_monitor_control, one clock, reset low. */
`timescale 1ns/1ns
module smc_supply_monitor_control_asserts (
  input wire       clk,
  input wire       resetn,
  input wire [8:0] cpu_addr,
  input wire       extended_io_bank_flag,
  input wire       cpu_wr,
  input wire       cpu_rd,
  input wire [7:0] cpu_wdata,
  input wire       precision_reset_comparator,
  input wire       low_voltage_comparator,
  input wire [7:0] cpu_rdata,
  input wire       cpu_rd_hit,
  input wire [1:0] precision_reset_level,
  input wire [2:0] low_voltage_trip_select,
  input wire       system_reset_req,
  input wire       low_voltage_irq,
  input wire       flash_enable
);
  wire fl = extended_io_bank_flag;
  wire lv = low_voltage_comparator;
  wire pc = precision_reset_comparator;
  wire st_rd = cpu_rd && fl && cpu_addr == 9'h1e4;
  wire cf_wr = cpu_wr && fl && cpu_addr == 9'h1e3;
  // ----------
  // Properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_RD_REFUSE: assert property (cpu_rd && !fl |=> !cpu_rd_hit && cpu_rdata == 8'h00)
    else $error("read without bank flag answered");
  AST_WR_REFUSE: assert property (cpu_wr && !fl |-> ##2 $stable(precision_reset_level)
    && $stable(low_voltage_trip_select)) else $error("write without bank flag taken");
  AST_CFG_WRITE: assert property (cf_wr |-> ##2 {2'b00, precision_reset_level, 1'b0,
    low_voltage_trip_select} == ($past(cpu_wdata, 2) & 8'h37)) else $error("config fields wrong");
  AST_STAT_UPPER: assert property (st_rd |=> cpu_rd_hit && cpu_rdata[7:2] == 6'h00)
    else $error("status upper bits not zero");
  AST_STAT_BITS: assert property (($stable(lv) && $stable(pc))[*5] ##0 st_rd
    |=> cpu_rdata[1:0] == {$past(lv), $past(pc)}) else $error("status bits wrong");
  AST_RST_ON: assert property ((pc && precision_reset_level != 2'h3)[*4] |-> system_reset_req)
    else $error("reset not requested");
  AST_RST_OFF: assert property (precision_reset_level == 2'h3 && $past(precision_reset_level)
    == 2'h3 |-> !system_reset_req) else $error("reset not suppressed");
  AST_IRQ_RISE: assert property ($rose(lv) ##1 lv[*2] |=> low_voltage_irq && !flash_enable)
    else $error("trip not seen in time");
  AST_IRQ_PULSE: assert property (low_voltage_irq |=> !low_voltage_irq)
    else $error("interrupt longer than one cycle");
  cover property (cf_wr);
  cover property (st_rd ##1 cpu_rdata[1]);
  cover property (low_voltage_irq);
endmodule
bind smc_supply_monitor_control smc_supply_monitor_control_asserts chk_u (.*);

// ===== sim/smc_supply_monitor_control_bench.sv
/* Self-checking bench of the supply monitor control block.
   Assumes the checker is bound beside it and a 100 MHz clock. */
`timescale 1ns/1ns
module smc_supply_monitor_control_bench;
  logic clk = 0, resetn = 0, flg = 0, wr = 0, rd = 0, osc = 0, pc = 0, lv = 0, rd_q = 0;
  logic [8:0] ad = 0;
  logic [7:0] wd = 0, rdata, cfg;
  logic       hit, rst, pw, slp = 0;
  logic [8:0] offc = 0;
  logic [8:0] expq[$];
  int         miscompares = 0, cmp_count = 0, cyc = 0;
  smc_supply_monitor_control dut_u (.clk(clk), .resetn(resetn), .cpu_addr(ad),
    .extended_io_bank_flag(flg), .cpu_wr(wr), .cpu_rd(rd), .cpu_wdata(wd), .sleep_active(slp),
    .lsosc_32k(osc), .precision_reset_comparator(pc), .low_voltage_comparator(lv),
    .cpu_rdata(rdata), .cpu_rd_hit(hit), .precision_reset_level(), .low_voltage_trip_select(),
    .system_reset_req(rst), .low_voltage_irq(), .flash_enable(), .monitor_power_on(pw));
  // -----------------
  // Clocks and checks
  // -----------------
  initial begin
    forever #5 clk = ~clk;
  end
  always #154 osc = ~osc;
  always @(posedge osc) if (!pw) offc = offc + 9'h001;
  always @(posedge clk) begin
    rd_q <= rd;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop;
    end
  end
  always @(negedge clk) if (rd_q) cmp("rdata", expq.pop_front(), {hit, rdata});
  task cmp(input string n, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr_(input [8:0] a, input [7:0] d);
    @(posedge clk); #1 ad = a; wd = d; wr = 1;
    @(posedge clk); #1 wr = 0;
  endtask
  task rdx(input [8:0] a, input [8:0] e);
    @(posedge clk); #1 ad = a; rd = 1; expq.push_back(e);
    @(posedge clk); #1 rd = 0;
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h1510ddfb));
    repeat (10) @(posedge clk);
    #1 resetn = 1; flg = 1;
    rdx(9'h1e3, 9'h100);
    rdx(9'h1eb, 9'h100);
    rdx(9'h1e4, 9'h100);
    rdx(9'h1e5, 9'h000);
    $display("test reset values done");
    repeat (20) begin
      cfg = $urandom;
      wr_(9'h1e3, cfg); rdx(9'h1e3, {1'b1, cfg & 8'h37});
      wr_(9'h1eb, cfg); rdx(9'h1eb, {1'b1, cfg & 8'hc0});
    end
    $display("test field writes done");
    flg = 0; wr_(9'h1e3, 8'h15); rdx(9'h1e3, 9'h000);
    flg = 1; rdx(9'h1e3, {1'b1, cfg & 8'h37});
    $display("test bank flag done");
    for (int i = 0; i < 16; i++) begin
      wr_(9'h1e3, {2'b00, i[1:0], 4'h0});
      {lv, pc} = i[3:2];
      repeat (5) @(posedge clk);
      #1 cmp("reset", {8'h00, pc && i[1:0] != 2'h3}, {8'h00, rst});
      rdx(9'h1e4, {7'h40, lv, pc});
    end
    $display("test comparators done");
    wr_(9'h1eb, 8'hc0); slp = 1;
    @(negedge pw); offc = 0;
    @(posedge pw); cmp("off periods", 9'h007, offc);
    @(negedge pw); #1 slp = 0;
    @(posedge clk); #1 cmp("awake power", 9'h001, {8'h00, pw});
    $display("test duty cycle done");
    report_and_stop;
  end
endmodule
